/* eewp_pkg.sv */
// Shared constants and types of the serial EEPROM bus slave write path.
package eewp_pkg;
  // ****************************************************************
  // Protocol constants
  // ****************************************************************
  localparam logic [2:0] TYPE_PREFIX = 3'h5;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned OFF_W = 7;
  localparam int unsigned GRP_BITS = 32;
  localparam int unsigned PAGE_GROUPS = 32;
  localparam int unsigned A10_POS = 2;
  localparam int unsigned LOCK_POS = 1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [31:0] PROG_CYCLES_DEF = 32'h0000_03E8;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  // ****************************************************************
  // Synchroniser lane positions
  // ****************************************************************
  localparam int unsigned SYNC_W = 7;
  localparam int unsigned SI_SCL = 0;
  localparam int unsigned SI_SDA = 1;
  localparam int unsigned SI_TOG = 2;
  localparam int unsigned SI_WP = 3;
  localparam int unsigned SI_CE = 4;
  // ****************************************************************
  // Protocol states, Gray coded along the write path
  // ****************************************************************
  typedef enum logic [2:0] {
    EEWP_IDLE = 3'h0,
    EEWP_SEL = 3'h1,
    EEWP_AHI = 3'h3,
    EEWP_ALO = 3'h2,
    EEWP_DATA = 3'h6,
    EEWP_PROG = 3'h7,
    EEWP_SKIP = 3'h5
  } eewp_state_t;
endpackage : eewp_pkg

/* eewp_sync.sv */
// Three-stage input synchroniser with agreement filter, plus the SCL-domain bit catcher.
`timescale 1ns/1ps
`default_nettype none
module eewp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } eewp_sync_t;
  eewp_sync_t q_ff, nxt_q;
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = din;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    // A lane moves only once two stages agree, so one-cycle glitches die here.
    for (int i = 0; i < WIDTH; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.out[i] = q_ff.s3[i];
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign dout = q_ff.out;
endmodule : eewp_sync

// The data bit is captured on the bus clock itself and held until the next edge,
// so the system side reads it only after the toggle has crossed.
module eewp_link (
  input wire logic scl_clk,
  input wire logic rstn,
  input wire logic sda_i,
  output logic bit_tog,
  output logic bit_val
);
  typedef struct packed {
    logic tog;
    logic val;
  } eewp_link_t;
  eewp_link_t q_ff, nxt_q;
  always_comb begin
    nxt_q.tog = ~q_ff.tog;
    nxt_q.val = sda_i;
  end
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign bit_tog = q_ff.tog;
  assign bit_val = q_ff.val;
endmodule : eewp_link
`default_nettype wire

/* eewp_store.sv */
// Group-organised storage with per-group single-bit correction code.
`timescale 1ns/1ps
`default_nettype none
module eewp_store #(
  parameter int unsigned IDX_W = 15,
  parameter int unsigned GROUPS = 16416
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [IDX_W-1:0] idx,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  // Check word: XOR of one-based positions of set bits, plus overall parity.
  function automatic logic [6:0] eewp_chk(input logic [31:0] w);
    logic [6:0] c;
    c = '0;
    for (int i = 0; i < 32; i++) begin
      if (w[i]) begin
        c = {~c[6], c[5:0] ^ 6'(i + 1)};
      end
    end
    return c;
  endfunction : eewp_chk
  localparam logic [6:0] ERASED_CHK = eewp_chk(eewp_pkg::ERASED_WORD);
  logic [38:0] mem_ff [GROUPS];
  logic [6:0] syn;
  always_comb begin
    rdata = mem_ff[idx][31:0];
    syn = mem_ff[idx][38:32] ^ eewp_chk(mem_ff[idx][31:0]);
    // Odd parity error with an in-range position is a single flipped data bit.
    if (syn[6] && syn[5:0] != 6'h00 && syn[5:0] <= 6'h20) begin
      rdata[syn[4:0] - 5'h01] = ~rdata[syn[4:0] - 5'h01];
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < GROUPS; i++) begin
        mem_ff[i] <= {ERASED_CHK, eewp_pkg::ERASED_WORD};
      end
    end else if (we) begin
      mem_ff[idx] <= {eewp_chk(wdata), wdata};
    end
  end
endmodule : eewp_store
`default_nettype wire

/* eewp_top.sv */
// Two-wire bus slave write path: protocol engine, page buffer and write cycle.
`timescale 1ns/1ps
`default_nettype none
module eewp_top #(
  parameter int unsigned ADDR_W = 16,
  parameter logic [31:0] PROG_CYCLES = eewp_pkg::PROG_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic chip_sel_pin_2,
  input wire logic chip_sel_pin_1,
  input wire logic chip_sel_pin_0,
  input wire logic write_protect_input,
  output logic busy,
  output logic [ADDR_W-1:0] addr_cnt,
  output logic id_locked
);
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned PG_W = ADDR_W - eewp_pkg::OFF_W;
  localparam int unsigned IDX_W = ADDR_W - 1;
  localparam int unsigned MAIN_GROUPS = 2 ** (ADDR_W - 2);
  localparam int unsigned GROUPS = MAIN_GROUPS + eewp_pkg::PAGE_GROUPS;
  localparam int unsigned PB = eewp_pkg::PAGE_BYTES;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    eewp_pkg::eewp_state_t st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic tgl;
    logic scl_q;
    logic sda_q;
    logic oe;
    logic ackw;
    logic id;
    logic lockc;
    logic lockd;
    logic nby;
    logic [7:0] hi;
    logic [PG_W-1:0] page;
    logic [eewp_pkg::OFF_W-1:0] off;
    logic [PB*8-1:0] pbuf;
    logic [PB-1:0] vld;
    logic [31:0] cnt;
    logic busy;
    logic [ADDR_W-1:0] addr;
    logic locked;
  } eewp_core_t;
  eewp_core_t q_ff, nxt_q;

  // ****************************************************************
  // Pin crossing
  // ****************************************************************
  logic link_tog;
  logic link_bit;
  logic [eewp_pkg::SYNC_W-1:0] sync_in;
  logic [eewp_pkg::SYNC_W-1:0] sync_o;

  eewp_link u_link (
    .scl_clk(scl_clk),
    .rstn(rstn),
    .sda_i(sda_i),
    .bit_tog(link_tog),
    .bit_val(link_bit)
  );

  // Floating chip-enable pins are pulled low at the pad, so they arrive as zero.
  assign sync_in = {chip_sel_pin_2, chip_sel_pin_1, chip_sel_pin_0,
                    write_protect_input, link_tog, sda_i, scl_i};

  eewp_sync #(
    .WIDTH(eewp_pkg::SYNC_W)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(sync_in),
    .dout(sync_o)
  );

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic mem_we;
  logic [IDX_W-1:0] mem_idx;
  logic [31:0] mem_wd;
  logic [31:0] mem_rd;

  eewp_store #(
    .IDX_W(IDX_W),
    .GROUPS(GROUPS)
  ) u_store (
    .clk(clk),
    .rstn(rstn),
    .we(mem_we),
    .idx(mem_idx),
    .wdata(mem_wd),
    .rdata(mem_rd)
  );

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  logic scl;
  logic sda;
  logic wp;
  logic bit_ev;
  logic start;
  logic stop;
  logic store;
  logic [7:0] bv;
  logic [4:0] grp;
  logic [6:0] boff;

  always_comb begin
    nxt_q = q_ff;
    store = 1'b0;
    scl = sync_o[eewp_pkg::SI_SCL];
    sda = sync_o[eewp_pkg::SI_SDA];
    wp = sync_o[eewp_pkg::SI_WP];
    bit_ev = sync_o[eewp_pkg::SI_TOG] != q_ff.tgl;
    bv = {q_ff.sh[6:0], link_bit};
    grp = q_ff.cnt[4:0];
    boff = '0;
    nxt_q.tgl = sync_o[eewp_pkg::SI_TOG];
    nxt_q.scl_q = scl;
    nxt_q.sda_q = sda;
    start = q_ff.scl_q && scl && q_ff.sda_q && !sda;
    stop = q_ff.scl_q && scl && !q_ff.sda_q && sda;

    // Pull low from the falling edge after bit eight until the falling edge after nine.
    if (q_ff.bitc == eewp_pkg::BIT_ACK && q_ff.ackw && !scl) begin
      nxt_q.oe = 1'b1;
    end else if (q_ff.bitc != eewp_pkg::BIT_ACK && !scl) begin
      nxt_q.oe = 1'b0;
    end

    if (bit_ev && q_ff.st != eewp_pkg::EEWP_IDLE && q_ff.st != eewp_pkg::EEWP_PROG) begin
      if (q_ff.bitc == eewp_pkg::BIT_ACK) begin
        nxt_q.bitc = '0;
      end else begin
        nxt_q.sh = bv;
        nxt_q.bitc = q_ff.bitc + 4'h1;
      end
      if (q_ff.bitc == eewp_pkg::BIT_LAST) begin
        unique case (q_ff.st)
          eewp_pkg::EEWP_SEL: begin
            nxt_q.id = bv[4];
            if (bv[7:5] != eewp_pkg::TYPE_PREFIX
                || bv[3:1] != sync_o[eewp_pkg::SI_CE +: 3]) begin
              nxt_q.st = eewp_pkg::EEWP_IDLE;
              nxt_q.ackw = 1'b0;
            end else begin
              nxt_q.ackw = 1'b1;
              // Reads are served by another path; this engine only waits for a stop or a new start.
              nxt_q.st = bv[0] ? eewp_pkg::EEWP_SKIP : eewp_pkg::EEWP_AHI;
            end
          end
          eewp_pkg::EEWP_AHI: begin
            nxt_q.hi = bv;
            nxt_q.ackw = 1'b1;
            nxt_q.st = eewp_pkg::EEWP_ALO;
          end
          eewp_pkg::EEWP_ALO: begin
            nxt_q.page = PG_W'({q_ff.hi, bv} >> eewp_pkg::OFF_W);
            nxt_q.off = bv[eewp_pkg::OFF_W-1:0];
            nxt_q.lockc = q_ff.id && q_ff.hi[eewp_pkg::A10_POS];
            nxt_q.lockd = 1'b0;
            nxt_q.nby = 1'b0;
            nxt_q.vld = '0;
            nxt_q.ackw = 1'b1;
            nxt_q.st = eewp_pkg::EEWP_DATA;
          end
          eewp_pkg::EEWP_DATA: begin
            store = !wp && !(q_ff.id && q_ff.locked);
            nxt_q.ackw = store;
            if (store) begin
              nxt_q.pbuf[q_ff.off*8 +: 8] = bv;
              nxt_q.vld[q_ff.off] = 1'b1;
              nxt_q.nby = 1'b1;
              nxt_q.off = q_ff.off + 7'h01;
              if (bv[eewp_pkg::LOCK_POS]) begin
                nxt_q.lockd = 1'b1;
              end
            end
          end
          default: begin
            nxt_q.ackw = 1'b0;
          end
        endcase
      end
    end

    if (start && q_ff.st != eewp_pkg::EEWP_PROG) begin
      nxt_q.st = eewp_pkg::EEWP_SEL;
      nxt_q.bitc = '0;
      nxt_q.ackw = 1'b0;
      nxt_q.oe = 1'b0;
    end else if (stop && q_ff.st != eewp_pkg::EEWP_PROG) begin
      nxt_q.oe = 1'b0;
      nxt_q.ackw = 1'b0;
      // The stop's own clock rise already counts as the first bit of the tenth slot.
      // So the page commits only when exactly that one bit follows a data acknowledge.
      if (q_ff.st == eewp_pkg::EEWP_DATA && q_ff.bitc == 4'h1 && q_ff.nby) begin
        nxt_q.st = eewp_pkg::EEWP_PROG;
        nxt_q.busy = 1'b1;
        nxt_q.cnt = '0;
      end else begin
        nxt_q.st = eewp_pkg::EEWP_IDLE;
      end
    end

    // The first PAGE_GROUPS cycles of the write cycle rewrite the page group by group.
    mem_we = 1'b0;
    mem_idx = q_ff.id ? IDX_W'(MAIN_GROUPS + 32'(grp)) : IDX_W'({q_ff.page, grp});
    mem_wd = mem_rd;
    for (int b = 0; b < 4; b++) begin
      boff = {grp, 2'(b)};
      if (q_ff.vld[boff]) begin
        mem_wd[b*8 +: 8] = q_ff.pbuf[32'(boff)*8 +: 8];
        mem_we = q_ff.st == eewp_pkg::EEWP_PROG && q_ff.cnt < 32'(eewp_pkg::PAGE_GROUPS)
                 && !q_ff.lockc;
      end
    end

    if (q_ff.st == eewp_pkg::EEWP_PROG) begin
      nxt_q.oe = 1'b0;
      nxt_q.cnt = q_ff.cnt + 32'h1;
      if (q_ff.cnt >= PROG_CYCLES - 32'h1) begin
        nxt_q.busy = 1'b0;
        nxt_q.st = eewp_pkg::EEWP_IDLE;
        nxt_q.addr = {q_ff.page, q_ff.off};
        nxt_q.locked = q_ff.locked || (q_ff.lockc && q_ff.lockd);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The pin is open drain: only the enable moves, the driven level is always low.
  assign sda_o = 1'b0;
  assign sda_oe = q_ff.oe;
  assign busy = q_ff.busy;
  assign addr_cnt = q_ff.addr;
  assign id_locked = q_ff.locked;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence commit_s;
    $rose(q_ff.busy);
  endsequence
  sequence hold_s;
    q_ff.busy [*8];
  endsequence

  start_enter_a: assert property (start && q_ff.st != eewp_pkg::EEWP_PROG
    |=> q_ff.st == eewp_pkg::EEWP_SEL && q_ff.bitc == 4'h0)
    else $error("start not taken");
  busy_quiet_a: assert property (q_ff.st == eewp_pkg::EEWP_PROG |=> !sda_oe)
    else $error("data driven while busy");
  prog_ignore_a: assert property (q_ff.st == eewp_pkg::EEWP_PROG && start
    && q_ff.cnt < PROG_CYCLES - 32'h1 |=> q_ff.st == eewp_pkg::EEWP_PROG)
    else $error("start accepted during write cycle");
  ack_slot_a: assert property ($rose(sda_oe) |-> $past(q_ff.bitc) == eewp_pkg::BIT_ACK
    && $past(q_ff.ackw) && !$past(scl))
    else $error("acknowledge outside ninth bit");
  wp_nack_a: assert property (q_ff.st == eewp_pkg::EEWP_DATA && bit_ev
    && q_ff.bitc == eewp_pkg::BIT_LAST && wp |=> !q_ff.ackw && !$changed(q_ff.vld))
    else $error("protected data byte accepted");
  ce_miss_a: assert property (q_ff.st == eewp_pkg::EEWP_SEL && bit_ev
    && q_ff.bitc == eewp_pkg::BIT_LAST && bv[3:1] != sync_o[eewp_pkg::SI_CE +: 3] && !start
    |=> q_ff.st == eewp_pkg::EEWP_IDLE ##1 !sda_oe)
    else $error("mismatched select answered");
  page_wrap_a: assert property (store |=> q_ff.off == $past(q_ff.off) + 7'h01
    && q_ff.page == $past(q_ff.page))
    else $error("in-page counter did not advance");
  commit_cause_a: assert property (commit_s |-> $past(q_ff.st) == eewp_pkg::EEWP_DATA
    && $past(q_ff.bitc) == 4'h1 && $past(q_ff.nby))
    else $error("write cycle from wrong slot");
  busy_len_a: assert property (commit_s |-> hold_s)
    else $error("write cycle too short");
  addr_next_a: assert property ($fell(q_ff.busy) |-> q_ff.addr == {$past(q_ff.page),
    $past(q_ff.off)})
    else $error("address counter not advanced");
endmodule : eewp_top
`default_nettype wire

/* eewp_master.sv */
// Behavioural two-wire bus master that clocks the link and pulls data low open-drain.
`timescale 1ns/1ps
`default_nettype none
module eewp_master #(
  parameter int unsigned QTR_NS = 256
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  int unsigned slow;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    slow = 0;
  end
  // ********************
  // Bus phases
  // ********************
  // The clock rests high between frames, so the slave sees no stray edge there.
  task automatic start_c();
    scl = 1'b0;
    #QTR_NS sda_low = 1'b0;
    #QTR_NS scl = 1'b1;
    #QTR_NS sda_low = 1'b1;
    #QTR_NS;
  endtask : start_c
  task automatic stop_c();
    scl = 1'b0;
    #QTR_NS sda_low = 1'b1;
    #QTR_NS scl = 1'b1;
    #QTR_NS sda_low = 1'b0;
    #QTR_NS;
  endtask : stop_c
  // A slow master only stretches the low phase; data still moves only while the clock is low.
  task automatic bit_c(input logic b, output logic got);
    scl = 1'b0;
    #(QTR_NS * (slow + 1)) sda_low = !b;
    #QTR_NS scl = 1'b1;
    #QTR_NS got = sda;
    #QTR_NS;
  endtask : bit_c
  task automatic byte_c(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], g);
    end
    bit_c(1'b1, g);
    ack = !g;
  endtask : byte_c
endmodule : eewp_master
`default_nettype wire

/* eewp_top_tb.sv */
// Self-checking bench of the write path driven by the behavioural bus master.
`timescale 1ns/1ps
`default_nettype none
module eewp_top_tb;
  localparam logic [31:0] PROG = 32'h0000_0190;
  logic clk;
  logic rstn;
  logic scl;
  logic m_low;
  wire sda;
  logic sda_o;
  logic sda_oe;
  logic [2:0] ce;
  logic wp;
  logic busy;
  logic [15:0] addr_cnt;
  logic id_locked;
  logic ack;
  logic oe_in_busy;
  int errors;
  int cmp_count;
  int busy_n;
  int busy_len;
  // The pull-up wins unless a party pulls low.
  assign sda = !(m_low || (sda_oe && !sda_o));
  eewp_master mst_u (
    .scl(scl),
    .sda_low(m_low),
    .sda(sda)
  );
  eewp_top #(
    .ADDR_W(16),
    .PROG_CYCLES(PROG)
  ) dut_u (
    .clk(clk),
    .rstn(rstn),
    .scl_clk(scl),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .chip_sel_pin_2(ce[2]),
    .chip_sel_pin_1(ce[1]),
    .chip_sel_pin_0(ce[0]),
    .write_protect_input(wp),
    .busy(busy),
    .addr_cnt(addr_cnt),
    .id_locked(id_locked)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busy_n <= busy_n + 1;
      if (sda_oe !== 1'b0) begin
        oe_in_busy <= 1'b1;
      end
    end else if (busy_n != 0) begin
      busy_len <= busy_n;
      busy_n <= 0;
    end
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic frame(input logic [7:0] sel, input logic [15:0] adr, input logic [7:0] dat[$],
      input logic dat_ack);
    mst_u.start_c();
    mst_u.byte_c(sel, ack);
    chk(16'(ack), 16'h1);
    mst_u.byte_c(adr[15:8], ack);
    chk(16'(ack), 16'h1);
    mst_u.byte_c(adr[7:0], ack);
    chk(16'(ack), 16'h1);
    foreach (dat[i]) begin
      mst_u.byte_c(dat[i], ack);
      chk(16'(ack), 16'(dat_ack));
    end
    mst_u.stop_c();
  endtask : frame
  // A select sent while the cycle runs must be ignored, which doubles as a busy probe.
  task automatic wait_prog(input logic [15:0] exp_addr, input logic use_addr);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(16'(busy), 16'h1);
    mst_u.start_c();
    mst_u.byte_c({4'hA, ce, 1'b0}, ack);
    chk(16'(ack), 16'h0);
    mst_u.stop_c();
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk(16'(busy_len >= PROG - 1 && busy_len <= PROG + 1), 16'h1);
    if (use_addr) begin
      chk(addr_cnt, exp_addr);
    end
  endtask : wait_prog
  task automatic no_prog();
    repeat (40) @(posedge clk);
    chk(16'(busy), 16'h0);
  endtask : no_prog
  // ********************
  // Scenarios
  // ********************
  task automatic t_byte();
    frame({4'hA, ce, 1'b0}, 16'h1234, '{8'hA5}, 1'b1);
    wait_prog(16'h1235, 1'b1);
  endtask : t_byte
  // Pins at zero stand for straps left floating.
  task automatic t_select();
    @(posedge clk);
    ce <= 3'h0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      mst_u.start_c();
      mst_u.byte_c({4'hA, 3'(i), 1'b0}, ack);
      chk(16'(ack), 16'(i == 0));
      mst_u.stop_c();
    end
    mst_u.start_c();
    mst_u.byte_c(8'h90, ack);
    chk(16'(ack), 16'h0);
    mst_u.start_c();
    mst_u.byte_c(8'hA1, ack);
    chk(16'(ack), 16'h1);
    mst_u.byte_c(8'hFF, ack);
    mst_u.stop_c();
    no_prog();
    @(posedge clk);
    ce <= 3'h5;
    repeat (10) @(posedge clk);
  endtask : t_select
  task automatic t_page();
    mst_u.slow = 2;
    frame({4'hA, ce, 1'b0}, 16'h3F7E, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
    mst_u.slow = 0;
    wait_prog(16'h3F02, 1'b1);
  endtask : t_page
  task automatic t_wp();
    @(posedge clk);
    wp <= 1'b1;
    repeat (10) @(posedge clk);
    frame({4'hA, ce, 1'b0}, 16'h0010, '{8'h5A}, 1'b0);
    no_prog();
    chk(addr_cnt, 16'h3F02);
    @(posedge clk);
    wp <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : t_wp
  task automatic t_stop_mid();
    logic g;
    mst_u.start_c();
    mst_u.byte_c({4'hA, ce, 1'b0}, ack);
    mst_u.byte_c(8'h00, ack);
    mst_u.byte_c(8'h40, ack);
    mst_u.byte_c(8'h3C, ack);
    chk(16'(ack), 16'h1);
    for (int i = 0; i < 4; i++) begin
      mst_u.bit_c(1'b0, g);
    end
    mst_u.stop_c();
    no_prog();
  endtask : t_stop_mid
  task automatic t_id();
    frame({4'hB, ce, 1'b0}, 16'h0005, '{8'h77}, 1'b1);
    wait_prog(16'h0006, 1'b1);
    frame({4'hB, ce, 1'b0}, 16'h0400, '{8'hFD}, 1'b1);
    wait_prog(16'h0000, 1'b0);
    chk(16'(id_locked), 16'h0);
    frame({4'hB, ce, 1'b0}, 16'h0400, '{8'h02}, 1'b1);
    wait_prog(16'h0000, 1'b0);
    chk(16'(id_locked), 16'h1);
    frame({4'hB, ce, 1'b0}, 16'h0005, '{8'h88}, 1'b0);
    no_prog();
  endtask : t_id
  initial begin
    rstn = 1'b0;
    ce = 3'h5;
    wp = 1'b0;
    errors = 0;
    cmp_count = 0;
    busy_n = 0;
    busy_len = 0;
    oe_in_busy = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    chk(addr_cnt, 16'h0000);
    chk(16'({busy, id_locked, sda_oe}), 16'h0);
    t_byte();
    t_select();
    t_page();
    t_wp();
    t_stop_mid();
    t_id();
    chk(16'(oe_in_busy), 16'h0);
    close_out();
  end
  // The sequence needs well under one millisecond; twice that means a hang.
  initial begin
    #2_000_000;
    errors++;
    close_out();
  end
endmodule : eewp_top_tb
`default_nettype wire
